/* File: logic/fps_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fps_top #(
  parameter int MS_CYC = fps_pkg::MS_CYC
) (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  // AXI4-Lite write
  input  wire logic [11:0]       s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output var  logic              s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output var  logic              s_axi_wready_out,
  output var  logic [1:0]        s_axi_bresp_out,
  output var  logic              s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [11:0]       s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output var  logic              s_axi_arready_out,
  output var  logic [31:0]       s_axi_rdata_out,
  output var  logic [1:0]        s_axi_rresp_out,
  output var  logic              s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Frequency sources and blocking matrix
  input  wire logic [15:0]       first_voltage_input_in,
  input  wire logic [15:0]       second_voltage_input_in,
  input  wire logic [7:0]        block_in,
  // Stage outputs and events
  output var  logic [7:0]        start_out,
  output var  logic [7:0]        trip_out,
  output var  logic [7:0]        blocked_out,
  output var  logic              event_valid_out,
  output var  fps_pkg::fps_evt_t event_out
);
  localparam int N = fps_pkg::NSTG;

  logic [15:0] div_reg, div_next;
  logic [2:0]  sub_reg, sub_next;
  logic [31:0] ms_reg, ms_next;
  logic        tick_reg, tick_next;
  logic        smp_reg, smp_next;
  logic [15:0] freq_reg, freq_next;
  logic [2:0]  mode_reg, mode_next;
  logic [2:0]  grp_reg, grp_next;
  logic        trk_reg, trk_next;
  logic        allow_reg, allow_next;
  logic        fen_reg, fen_next;
  logic [15:0] en_reg, en_next;
  logic [15:0] frc_reg, frc_next;
  logic [15:0] pu_reg [64];
  logic [15:0] pu_next [64];
  logic [20:0] dly_reg [64];
  logic [20:0] dly_next [64];
  logic [63:0] used_reg, used_next;
  logic [7:0]  clr_vec;
  logic        awf_reg, awf_next, wf_reg, wf_next;
  logic        awr_reg, wr_reg, bv_reg, bv_next;
  logic [11:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  br_reg, br_next;
  logic        arr_reg, arr_next, rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0]  rr_reg, rr_next;
  logic        w_do;
  logic [32:0] wr_rv, rd_rv;
  logic [31:0] wmask, wr_nv;
  logic [2:0]  mode_eff;
  logic        m_off;
  logic        m_blk;
  logic [23:0] o_all, cur_all;
  logic [383:0] cnt_all;
  fps_pkg::fps_evt_t ev_next;

  assign mode_eff = allow_reg ? mode_reg : fps_pkg::MODE_ON;
  assign m_off = mode_eff == fps_pkg::MODE_OFF;
  assign m_blk = mode_eff == fps_pkg::MODE_BLK
              || mode_eff == fps_pkg::MODE_TBLK;

  // ---------------------------------------------------------------
  // Millisecond stamp and 5 ms sampling
  // ---------------------------------------------------------------
  always_comb begin
    div_next  = div_reg + 16'h1;
    sub_next  = sub_reg;
    ms_next   = ms_reg;
    tick_next = 1'b0;
    smp_next  = 1'b0;
    freq_next = freq_reg;
    if (div_reg == 16'(MS_CYC - 1)) begin
      div_next  = '0;
      tick_next = 1'b1;
      ms_next   = ms_reg + 32'h1;
      if (sub_reg == 3'(fps_pkg::SMP_MS - 1)) begin
        sub_next  = '0;
        smp_next  = 1'b1;
        freq_next = trk_reg ? second_voltage_input_in
                            : first_voltage_input_in;
      end else begin
        sub_next = sub_reg + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  function automatic logic [32:0] rd_fn(input logic [11:0] a);
    logic [32:0] v;
    logic [5:0]  si;
    v  = '0;
    si = a[8:3];
    if (a >= fps_pkg::A_SET && a < fps_pkg::A_SET_END) begin
      v[31:0] = a[2] ? 32'(dly_reg[si])
                     : {used_reg[si], 15'h0, pu_reg[si]};
    end else if (a >= fps_pkg::A_CNT && a < fps_pkg::A_CNT_END) begin
      if (a[3:2] == 2'h3) begin
        v[32] = 1'b1;
      end else begin
        v[31:0] = 32'(cnt_all[int'(a[6:4]) * 48 + int'(a[3:2]) * 16 +: 16]);
      end
    end else begin
      case ({a[11:2], 2'h0})
        fps_pkg::A_CTRL: v[31:0] = 32'({fen_reg, allow_reg, trk_reg,
                                        1'b0, grp_reg, 1'b0, mode_reg});
        fps_pkg::A_EN:   v[31:0] = 32'(en_reg);
        fps_pkg::A_FRC:  v[31:0] = 32'(frc_reg);
        fps_pkg::A_STAT: v[31:0] = {8'h0, blocked_out, trip_out, start_out};
        fps_pkg::A_CLR:  v[31:0] = '0;
        fps_pkg::A_TIME: v[31:0] = ms_reg;
        fps_pkg::A_FREQ: v[31:0] = 32'(freq_reg);
        default:         v[32] = 1'b1;
      endcase
    end
    return v;
  endfunction

  // Process form so register contents, not only the address, retrigger
  always_comb begin
    wr_rv = rd_fn(awa_reg);
    rd_rv = rd_fn(s_axi_araddr_in);
  end
  assign wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}},
                  {8{ws_reg[1]}}, {8{ws_reg[0]}}};
  assign wr_nv = (wr_rv[31:0] & ~wmask) | (wd_reg & wmask);
  assign w_do  = awf_reg && wf_reg && !bv_reg;

  // ---------------------------------------------------------------
  // Bus handshakes
  // ---------------------------------------------------------------
  always_comb begin
    awf_next = awf_reg;
    awa_next = awa_reg;
    wf_next  = wf_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    if (s_axi_awvalid_in && awr_reg) begin
      awf_next = 1'b1;
      awa_next = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wr_reg) begin
      wf_next = 1'b1;
      wd_next = s_axi_wdata_in;
      ws_next = s_axi_wstrb_in;
    end
    if (w_do) begin
      awf_next = 1'b0;
      wf_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = wr_rv[32] ? fps_pkg::RESP_ERR : fps_pkg::RESP_OK;
    end
    if (bv_reg && s_axi_bready_in) begin
      bv_next = 1'b0;
    end
    arr_next = arr_reg;
    rv_next  = rv_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    if (s_axi_arvalid_in && arr_reg) begin
      arr_next = 1'b0;
      rv_next  = 1'b1;
      rd_next  = rd_rv[31:0];
      rr_next  = rd_rv[32] ? fps_pkg::RESP_ERR : fps_pkg::RESP_OK;
    end
    if (rv_reg && s_axi_rready_in) begin
      rv_next  = 1'b0;
      arr_next = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Static settings and setting groups
  // ---------------------------------------------------------------
  always_comb begin
    mode_next  = mode_reg;
    grp_next   = grp_reg;
    trk_next   = trk_reg;
    allow_next = allow_reg;
    fen_next   = fen_reg;
    en_next    = en_reg;
    frc_next   = frc_reg;
    pu_next    = pu_reg;
    dly_next   = dly_reg;
    used_next  = used_reg;
    clr_vec    = '0;
    if (w_do && !wr_rv[32]) begin
      if (awa_reg >= fps_pkg::A_SET) begin
        if (awa_reg[2]) begin
          dly_next[awa_reg[8:3]] = wr_nv[20:0];
        end else begin
          pu_next[awa_reg[8:3]]   = wr_nv[15:0];
          used_next[awa_reg[8:3]] = wr_nv[fps_pkg::B_USED];
        end
      end else begin
        case ({awa_reg[11:2], 2'h0})
          fps_pkg::A_CTRL: begin
            if (allow_reg && wr_nv[2:0] >= fps_pkg::MODE_ON
                && wr_nv[2:0] <= fps_pkg::MODE_OFF) begin
              mode_next = wr_nv[fps_pkg::B_MODE +: 3];
            end
            grp_next   = wr_nv[fps_pkg::B_GRP +: 3];
            trk_next   = wr_nv[fps_pkg::B_TRK];
            allow_next = wr_nv[fps_pkg::B_ALLOW];
            fen_next   = wr_nv[fps_pkg::B_FEN];
          end
          fps_pkg::A_EN:  en_next  = wr_nv[15:0];
          fps_pkg::A_FRC: frc_next = wr_nv[15:0];
          fps_pkg::A_CLR: clr_vec  = wr_nv[7:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_stg
    fps_pkg::fps_cfg_t cfg;
    logic              s_raw, t_raw, b_raw, run;
    logic [1:0]        fc;
    logic [2:0]        o_n, rise;
    logic [15:0]       c_reg [3];
    logic [15:0]       c_next [3];

    assign cfg.pickup = pu_reg[{grp_reg, 3'(i)}];
    assign cfg.delay  = dly_reg[{grp_reg, 3'(i)}];
    assign cfg.used   = used_reg[{grp_reg, 3'(i)}];
    assign run = en_reg[2*i +: 2] == fps_pkg::EN_YES
              && cfg.used && !m_off;

    fps_stage #(
      .OVER (i < fps_pkg::NOVER)
    ) u_stage (
      .clock_in    (clock_in),
      .rst_b_in    (rst_b_in),
      .tick_ms_in  (tick_reg),
      .sample_in   (smp_reg),
      .freq_in     (freq_reg),
      .cfg_in      (cfg),
      .en_in       (run),
      .blk_in      (block_in[i] | m_blk),
      .start_out   (s_raw),
      .trip_out    (t_raw),
      .blocked_out (b_raw)
    );

    assign fc = frc_reg[2*i +: 2];
    always_comb begin
      o_n = {b_raw, t_raw, s_raw};
      if (fen_reg) begin
        unique case (fc)
          fps_pkg::FRC_NORM:  o_n = {b_raw, t_raw, s_raw};
          fps_pkg::FRC_START: o_n = 3'h1;
          fps_pkg::FRC_TRIP:  o_n = 3'h3;
          fps_pkg::FRC_BLK:   o_n = 3'h4;
        endcase
      end
    end
    assign cur_all[3*i +: 3] = {blocked_out[i], trip_out[i], start_out[i]};
    assign o_all[3*i +: 3]   = o_n;
    assign rise = o_n & ~cur_all[3*i +: 3];

    always_comb begin
      for (int k = 0; k < 3; k++) begin
        c_next[k] = c_reg[k];
        if (rise[k]) begin
          c_next[k] = clr_vec[i] ? 16'h1 : c_reg[k] + 16'h1;
        end else if (clr_vec[i]) begin
          c_next[k] = '0;
        end
      end
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        c_reg <= '{default: 16'h0};
      end else begin
        c_reg <= c_next;
      end
    end
    assign cnt_all[48*i +: 48] = {c_reg[2], c_reg[1], c_reg[0]};
  end

  always_comb begin
    ev_next.rise  = o_all & ~cur_all;
    ev_next.fall  = cur_all & ~o_all;
    ev_next.stamp = ms_reg;
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_reg <= '0;
      sub_reg <= '0;
      ms_reg <= '0;
      tick_reg <= 1'b0;
      smp_reg <= 1'b0;
      freq_reg <= '0;
      mode_reg <= fps_pkg::MODE_ON;
      grp_reg <= '0;
      trk_reg <= 1'b0;
      allow_reg <= 1'b0;
      fen_reg <= 1'b0;
      en_reg <= fps_pkg::RST_EN;
      frc_reg <= '0;
      for (int j = 0; j < 64; j++) begin
        pu_reg[j] <= (j % N < fps_pkg::NOVER) ? fps_pkg::RST_PU_OVER
                                             : fps_pkg::RST_PU_UNDER;
        dly_reg[j] <= fps_pkg::RST_DLY;
      end
      used_reg <= '0;
      awf_reg <= 1'b0;
      awr_reg <= 1'b1;
      awa_reg <= '0;
      wf_reg <= 1'b0;
      wr_reg <= 1'b1;
      wd_reg <= '0;
      ws_reg <= '0;
      bv_reg <= 1'b0;
      br_reg <= fps_pkg::RESP_OK;
      arr_reg <= 1'b1;
      rv_reg <= 1'b0;
      rd_reg <= '0;
      rr_reg <= fps_pkg::RESP_OK;
      start_out <= '0;
      trip_out <= '0;
      blocked_out <= '0;
      event_valid_out <= 1'b0;
      event_out <= '0;
    end else begin
      div_reg <= div_next;
      sub_reg <= sub_next;
      ms_reg <= ms_next;
      tick_reg <= tick_next;
      smp_reg <= smp_next;
      freq_reg <= freq_next;
      mode_reg <= mode_next;
      grp_reg <= grp_next;
      trk_reg <= trk_next;
      allow_reg <= allow_next;
      fen_reg <= fen_next;
      en_reg <= en_next;
      frc_reg <= frc_next;
      pu_reg <= pu_next;
      dly_reg <= dly_next;
      used_reg <= used_next;
      awf_reg <= awf_next;
      awr_reg <= !awf_next;
      awa_reg <= awa_next;
      wf_reg <= wf_next;
      wr_reg <= !wf_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      arr_reg <= arr_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      for (int j = 0; j < N; j++) begin
        start_out[j] <= o_all[3*j];
        trip_out[j] <= o_all[3*j+1];
        blocked_out[j] <= o_all[3*j+2];
      end
      event_valid_out <= |(o_all ^ cur_all);
      event_out <= ev_next;
    end
  end

  assign s_axi_awready_out = awr_reg;
  assign s_axi_wready_out  = wr_reg;
  assign s_axi_bvalid_out  = bv_reg;
  assign s_axi_bresp_out   = br_reg;
  assign s_axi_arready_out = arr_reg;
  assign s_axi_rvalid_out  = rv_reg;
  assign s_axi_rdata_out   = rd_reg;
  assign s_axi_rresp_out   = rr_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  off_mode_a: assert property (
    m_off && !fen_reg ##1 m_off && !fen_reg ##1 m_off && !fen_reg
    |-> start_out == '0 && trip_out == '0)
    else $error("Stage active in off mode");
  mode_lock_a: assert property (
    !allow_reg && !$past(allow_reg) |-> $stable(mode_reg))
    else $error("Mode changed while locked");
  stage_off_a: assert property (
    (en_reg[1:0] == fps_pkg::EN_NO && !fen_reg) [*3] |-> !start_out[0])
    else $error("Disabled stage started");
  force_blk_a: assert property (
    (fen_reg && frc_reg[1:0] == fps_pkg::FRC_BLK) [*2]
    |-> blocked_out[0] && !start_out[0])
    else $error("Forced blocked not shown");
  evt_edge_a: assert property (
    $changed(start_out) || $changed(blocked_out) |-> event_valid_out)
    else $error("Output change without event");
  evt_trip_a: assert property (
    $rose(trip_out[4]) |-> event_out.rise[13])
    else $error("Trip rise not in event");
  evt_stamp_a: assert property (
    event_valid_out |-> event_out.stamp == $past(ms_reg))
    else $error("Event stamp wrong");
  smp_grid_a: assert property (
    smp_reg |-> tick_reg && ms_reg % 32'd5 == 32'd0)
    else $error("Sample off the 5 ms grid");
  cnt_clr_a: assert property (
    clr_vec[0] && !(o_all[0] && !cur_all[0]) |=> cnt_all[15:0] == '0)
    else $error("Start counter not cleared");

  trip_c: cover property ($rose(trip_out[0]));
  blk_c: cover property ($rose(blocked_out[4]));
  inst_c: cover property (event_out.rise[0] && event_out.rise[1]);
endmodule
`default_nettype wire

/* File: logic/fps_pkg.sv */
`default_nettype none
package fps_pkg;
  localparam int NSTG      = 8;
  localparam int NOVER     = 4;
  localparam int NGRP      = 8;
  localparam int CLK_NS    = 25;
  localparam int MS_NS     = 1000000;
  localparam int MS_CYC    = MS_NS / CLK_NS;
  localparam int SMP_MS    = 5;
  localparam int F_LSB_MHZ = 10;
  localparam int HYST_MHZ  = 20;
  localparam logic [15:0] HYST = 16'(HYST_MHZ / F_LSB_MHZ);
  // ---------------------------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [11:0] A_CTRL    = 12'h000;
  localparam logic [11:0] A_EN      = 12'h004;
  localparam logic [11:0] A_FRC     = 12'h008;
  localparam logic [11:0] A_STAT    = 12'h00c;
  localparam logic [11:0] A_CLR     = 12'h010;
  localparam logic [11:0] A_TIME    = 12'h014;
  localparam logic [11:0] A_FREQ    = 12'h018;
  localparam logic [11:0] A_CNT     = 12'h100;
  localparam logic [11:0] A_CNT_END = 12'h180;
  localparam logic [11:0] A_SET     = 12'h400;
  localparam logic [11:0] A_SET_END = 12'h600;
  localparam int B_MODE  = 0;
  localparam int B_GRP   = 4;
  localparam int B_TRK   = 8;
  localparam int B_ALLOW = 9;
  localparam int B_FEN   = 10;
  localparam int B_USED  = 31;
  localparam logic [2:0] MODE_ON   = 3'h1;
  localparam logic [2:0] MODE_BLK  = 3'h2;
  localparam logic [2:0] MODE_TBLK = 3'h4;
  localparam logic [2:0] MODE_OFF  = 3'h5;
  localparam logic [1:0] EN_NO     = 2'h1;
  localparam logic [1:0] EN_YES    = 2'h2;
  localparam logic [1:0] FRC_NORM  = 2'h0;
  localparam logic [1:0] FRC_START = 2'h1;
  localparam logic [1:0] FRC_TRIP  = 2'h2;
  localparam logic [1:0] FRC_BLK   = 2'h3;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  localparam logic [15:0] RST_EN   = 16'h5555;
  localparam logic [15:0] RST_PU_OVER  = 16'h13ec;
  localparam logic [15:0] RST_PU_UNDER = 16'h1324;
  localparam logic [20:0] RST_DLY  = 21'h00064;
  typedef struct packed {
    logic        used;
    logic [15:0] pickup;
    logic [20:0] delay;
  } fps_cfg_t;
  typedef struct packed {
    logic [23:0] rise;
    logic [23:0] fall;
    logic [31:0] stamp;
  } fps_evt_t;
endpackage
`default_nettype wire

/* File: logic/fps_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module fps_stage #(
  parameter bit OVER = 1'b1
) (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  // Timing and measurement
  input  wire logic              tick_ms_in,
  input  wire logic              sample_in,
  input  wire logic [15:0]       freq_in,
  // Settings and blocking
  input  wire fps_pkg::fps_cfg_t cfg_in,
  input  wire logic              en_in,
  input  wire logic              blk_in,
  // Stage state
  output var  logic              start_out,
  output var  logic              trip_out,
  output var  logic              blocked_out
);
  logic        pick_reg;
  logic        pick_next;
  logic        start_next;
  logic        trip_next;
  logic        blk_next;
  logic [20:0] cnt_reg;
  logic [20:0] cnt_next;
  logic [16:0] f17;
  logic [16:0] pu17;
  logic [16:0] lo17;
  logic [16:0] hi17;

  assign f17  = {1'b0, freq_in};
  assign pu17 = {1'b0, cfg_in.pickup};
  assign lo17 = pu17 - {1'b0, fps_pkg::HYST};
  assign hi17 = pu17 + {1'b0, fps_pkg::HYST};

  always_comb begin
    pick_next  = pick_reg;
    start_next = start_out;
    trip_next  = trip_out;
    blk_next   = blocked_out;
    cnt_next   = cnt_reg;
    if (sample_in) begin
      if (OVER) begin
        pick_next = pick_reg ? (f17 > lo17) : (f17 > pu17);
      end else begin
        pick_next = pick_reg ? (f17 < hi17) : (f17 < pu17);
      end
      blk_next   = pick_next & blk_in;
      start_next = pick_next & ~blk_in;
      if (!start_next) begin
        trip_next = 1'b0;
        cnt_next  = '0;
      end else if (cfg_in.delay == '0) begin
        trip_next = 1'b1;
      end
    end
    if (start_next && !trip_next && tick_ms_in && cfg_in.delay != '0) begin
      cnt_next = cnt_reg + 21'h1;
      if (cnt_next >= cfg_in.delay) begin
        trip_next = 1'b1;
      end
    end
    if (!en_in) begin
      pick_next  = 1'b0;
      start_next = 1'b0;
      trip_next  = 1'b0;
      blk_next   = 1'b0;
      cnt_next   = '0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pick_reg    <= 1'b0;
      start_out   <= 1'b0;
      trip_out    <= 1'b0;
      blocked_out <= 1'b0;
      cnt_reg     <= '0;
    end else begin
      pick_reg    <= pick_next;
      start_out   <= start_next;
      trip_out    <= trip_next;
      blocked_out <= blk_next;
      cnt_reg     <= cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  blk_excl_a: assert property (
    sample_in && en_in && blk_in |=> !start_out && !trip_out)
    else $error("Start kept under blocking");
  instant_a: assert property (
    $rose(start_out) && $past(cfg_in.delay) == '0 |-> $rose(trip_out))
    else $error("Instant stage did not trip with start");
  en_off_a: assert property (
    !en_in |=> !start_out && !trip_out && !blocked_out)
    else $error("Disabled stage active");
  hyst_hold_a: assert property (
    OVER && start_out && sample_in && en_in && !blk_in
    && f17 + {1'b0, fps_pkg::HYST} > pu17 |=> start_out)
    else $error("Release inside hysteresis band");
endmodule
`default_nettype wire

/* File: sim/fps_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fps_src_model (
  // Clock and wanted values
  input  wire logic        clock_in,
  input  wire logic [15:0] freq_in,
  input  wire logic [7:0]  blk_in,
  // Measurement and blocking matrix
  output var  logic [15:0] first_out,
  output var  logic [15:0] second_out,
  output var  logic [7:0]  block_out
);
  // Second input differs so a wrong source shows
  always_ff @(posedge clock_in) begin
    first_out  <= freq_in;
    second_out <= freq_in ^ 16'h00ff;
    block_out  <= blk_in;
  end
endmodule
`default_nettype wire

/* File: sim/frequency_protection_stages_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) samples_checked++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end
module frequency_protection_stages_tb;
  logic        clk = 1'h0, rst_b = 1'h0, run = 1'h1, sel = 1'h0;
  logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [11:0] aw = 12'h0, ar = 12'h0;
  logic [31:0] wd = 32'h0, rdat, rdata, lst = 32'hffffffff;
  logic [15:0] fq = 16'h1388, f1, f2;
  logic [7:0]  bk = 8'h0, blk, st, tr, bl, ps, pt, pb;
  logic [7:0]  es = 8'h0, et = 8'h0, eb = 8'h0;
  logic [23:0] er, ef;
  logic [1:0]  bresp, rresp, resp, pk = 2'h0;
  logic        awr, wrd, bv, arr, rv, ta, tw, tb, evv;
  fps_pkg::fps_evt_t ev;
  int bad_count = 0, samples_checked = 0, scnt = 0;
  always #12.5 clk = ~clk;
  fps_src_model src (.clock_in(clk), .freq_in(fq), .blk_in(bk),
    .first_out(f1), .second_out(f2), .block_out(blk));
  fps_top #(.MS_CYC(10)) uut (.clock_in(clk), .rst_b_in(rst_b),
    .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ar),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
    .first_voltage_input_in(f1), .second_voltage_input_in(f2),
    .block_in(blk), .start_out(st), .trip_out(tr), .blocked_out(bl),
    .event_valid_out(evv), .event_out(ev));
  // ----------------
  // Bus tasks
  // ----------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(negedge clk);
      {ta, tw, tb, resp} = {awr & awv, wrd & wv, bv, bresp};
      @(posedge clk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end while (tb !== 1'h1);
    bry <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    ar <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(negedge clk);
      {ta, tb, resp, rdat} = {arr & arv, rv, rresp, rdata};
      @(posedge clk);
      if (ta) arv <= 1'h0;
    end while (tb !== 1'h1);
    rry <= 1'h0;
  endtask
  // ----------------
  // Model and checks
  // ----------------
  task automatic step(input logic [15:0] f, input logic [7:0] b);
    int          nev;
    logic [15:0] fm;
    @(posedge clk);
    fm = sel ? f ^ 16'h00ff : f;
    fq <= f;
    bk <= b;
    pk[0] = pk[0] ? (fm > 16'h13ea) : (fm > 16'h13ec);
    pk[1] = pk[1] ? (fm < 16'h1326) : (fm < 16'h1324);
    {ps, pt, pb} = {es, et, eb};
    es = {3'h0, run & pk[1] & ~b[4], 3'h0, run & pk[0] & ~b[0]};
    eb = {3'h0, run & pk[1] & b[4], 3'h0, run & pk[0] & b[0]};
    et = es;
    for (int i = 0; i < 8; i++) begin
      er[3*i +: 3] = {eb[i], et[i], es[i]} & ~{pb[i], pt[i], ps[i]};
      ef[3*i +: 3] = ~{eb[i], et[i], es[i]} & {pb[i], pt[i], ps[i]};
    end
    scnt += int'(es[0] & ~ps[0]);
    nev = 0;
    repeat (100) begin
      @(negedge clk);
      if (evv === 1'h1) begin
        `CHK("rise", er, ev.rise)
        `CHK("fall", ef, ev.fall)
        // Mode changes land off the sample grid
        if (lst !== 32'hffffffff && run) begin
          `CHK("stamp", 32'h0, (ev.stamp - lst) % 5)
        end
        lst = ev.stamp;
        nev++;
      end
    end
    `CHK("events", int'((er | ef) != 24'h0), nev)
    `CHK("start", es, st)
    `CHK("trip", et, tr)
    `CHK("blocked", eb, bl)
  endtask
  task automatic wrap_up();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(97));
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(12'h004);
    `CHK("en_rst", fps_pkg::RST_EN, rdat[15:0])
    rd(12'h020);
    `CHK("unmapped", fps_pkg::RESP_ERR, resp)
    wr(12'h400, 32'h800013ec);
    wr(12'h404, 32'h0);
    wr(12'h420, 32'h80001324);
    wr(12'h424, 32'h0);
    wr(12'h004, 32'h5656);
    for (int i = 0; i < 24; i++) begin
      step((i < 12 ? 16'h13e8 : 16'h1320) + 16'($urandom % 8),
           8'($urandom) & 8'h11);
    end
    rd(12'h100);
    `CHK("cnt", 16'(scnt), rdat[15:0])
    wr(12'h010, 32'h1);
    rd(12'h100);
    `CHK("cnt_clr", 16'h0, rdat[15:0])
    step(16'h1300, 8'h0);
    wr(12'h000, 32'h305);
    sel = 1'h1;
    step(16'h1300, 8'h0);
    wr(12'h000, 32'h305);
    run = 1'h0;
    step(16'h1300, 8'h0);
    wr(12'h008, 32'h3);
    wr(12'h000, 32'h705);
    repeat (2) @(negedge clk);
    `CHK("force_blk", 8'h01, bl)
    `CHK("force_st", 8'h00, st)
    wrap_up();
  end
endmodule
`default_nettype wire
